// ### design/uart_flags_pkg.sv
// Constants shared by the serial status, data and flag block.
package uart_flags_pkg;
  // Register indices; the byte address is four times the index.
  localparam logic [9:0] IDX_CTRL_ONE = 10'h072;
  localparam logic [9:0] IDX_CTRL_TWO = 10'h073;
  localparam logic [9:0] IDX_STATUS_ONE = 10'h074;
  localparam logic [9:0] IDX_STATUS_TWO = 10'h075;
  localparam logic [9:0] IDX_DATA_HIGH = 10'h076;
  localparam logic [9:0] IDX_DATA_LOW = 10'h077;
  // Status one bit positions.
  localparam int FLAG_TX_EMPTY = 7;
  localparam int FLAG_TX_DONE = 6;
  localparam int FLAG_RX_FULL = 5;
  localparam int FLAG_IDLE = 4;
  localparam int FLAG_OVERRUN = 3;
  localparam int FLAG_NOISE = 2;
  localparam int FLAG_FRAMING = 1;
  localparam int FLAG_PARITY = 0;
  // Control one bit positions.
  localparam int C1_NINE_BIT = 4;
  localparam int C1_PARITY_EN = 1;
  localparam int C1_PARITY_ODD = 0;
  // Control two bit positions.
  localparam int C2_TX_EMPTY_IRQ = 7;
  localparam int C2_TX_DONE_IRQ = 6;
  localparam int C2_RX_IRQ = 5;
  localparam int C2_IDLE_IRQ = 4;
  localparam int C2_TX_ON = 3;
  localparam int C2_RX_ON = 2;
  localparam int C2_WAKEUP_MUTE = 1;
  // Data high bit positions.
  localparam int DH_RX_NINTH = 7;
  localparam int DH_TX_NINTH = 6;
  // Reset values.
  localparam logic [7:0] STATUS_ONE_RESET = 8'hC0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // Bit timing: clock cycles per sample tick and sample ticks per bit.
  localparam logic [3:0] SAMPLE_DIV = 4'h2;
  localparam logic [3:0] LAST_PHASE = 4'hF;
  localparam logic [3:0] VOTE_A = 4'h7;
  localparam logic [3:0] VOTE_B = 4'h8;
  localparam logic [3:0] VOTE_C = 4'h9;
  // Frame lengths in bits, start and stop included.
  localparam logic [3:0] FRAME_BITS_8 = 4'hA;
  localparam logic [3:0] FRAME_BITS_9 = 4'hB;
  // Bus responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### design/uart_status_data_flags.sv
// Serial interface status flags, data register pair, transmitter and receiver.
`timescale 1ns/1ps
// Operation
// - Tx empty set; cleared by status read, write
// - Tx done while idle; status read, write clears
// - Rx full on transfer; status read, read clears
// - Line idle after one full character of ones
// - Idle only after activity; muted suppresses
// - Overrun drops new character, keeps held one
// - Overrun cleared by status then data read
// - Noise flag on non-unanimous sample vote
// - Framing error on zero stop bit
// - Parity error on wrong received parity
// - Noise, framing, parity describe held char, no interrupt
// - Status one resets with tx flags set
// - Status two bit 0 shows receiver busy
// - Data read gives rx, write loads tx
// - High data holds ninth rx/tx bits
// - Enabling transmitter sets tx empty and done
// - Interrupt on tx empty when enabled
// - Interrupt on tx done when enabled
// - Disable mid-character finishes it, drops queue
// - Disable while idle releases pin on bit clock
// - Last character end still sets tx flags
// - Only reset stops the transmitter at once
// - Rx interrupt on full or overrun when enabled
// - Idle interrupt when its enable is set
// - Wakeup mute inhibits receiver interrupts
// - Nine-bit format adds one data bit
module uart_status_data_flags
  import uart_flags_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic rxd,
  output logic txd,
  output logic txd_oe,
  output logic irq
);
  typedef enum logic {TX_IDLE, TX_SEND} tx_state_e;
  typedef enum logic {RX_IDLE, RX_BITS} rx_state_e;

  // Bus holding registers.
  logic aw_held_q, w_held_q;
  logic [9:0] waddr_q;
  logic [7:0] wbyte_q;
  logic wlane_q;
  logic bvalid_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  // Software-visible control and status.
  logic [7:0] ctrl_one_q, ctrl_two_q;
  logic [7:0] flags_q; // Status one image.
  logic [7:0] armed_q; // Per flag: status read with it set.
  logic [7:0] flag_set; // Hardware set events.
  logic [7:0] flag_clr; // Qualifying data accesses per flag.
  // Transmit side.
  tx_state_e tx_state_q;
  logic [8:0] tx_buf_q; // Queued character with ninth bit.
  logic tx_pend_q; // Queue holds a character.
  logic tx_ninth_q;
  logic [10:0] tx_frame_q;
  logic [3:0] tx_left_q, tx_phase_q;
  logic tx_on_prev_q, txd_q, txd_oe_q;
  // Receive side.
  rx_state_e rx_state_q;
  logic [1:0] rxd_meta_q;
  logic [3:0] rx_phase_q, rx_bit_q;
  logic [2:0] votes_q;
  logic [9:0] rx_shift_q;
  logic rx_noise_q;
  logic [8:0] rx_hold_q; // Receive holding register.
  logic [7:0] idle_cnt_q;
  logic line_active_q;
  // Sample tick generator.
  logic [3:0] div_q;
  logic tick;

  // Decoded controls.
  logic nine, par_en, par_odd, tx_on, rx_on, mute;
  assign nine = ctrl_one_q[C1_NINE_BIT];
  assign par_en = ctrl_one_q[C1_PARITY_EN];
  assign par_odd = ctrl_one_q[C1_PARITY_ODD];
  assign tx_on = ctrl_two_q[C2_TX_ON];
  assign rx_on = ctrl_two_q[C2_RX_ON];
  assign mute = ctrl_two_q[C2_WAKEUP_MUTE];

  // Bus events.
  logic do_write, ar_take, wr_low, rd_low, rd_status;
  assign do_write = aw_held_q && w_held_q && !bvalid_q;
  assign ar_take = arvalid && !rvalid_q;
  assign wr_low = do_write && wlane_q && (waddr_q == IDX_DATA_LOW);
  assign rd_low = ar_take && (araddr[11:2] == IDX_DATA_LOW);
  assign rd_status = ar_take && (araddr[11:2] == IDX_STATUS_ONE);

  // Channel readies: each address or data beat is held until the pair completes.
  assign awready = !aw_held_q && !bvalid_q;
  assign wready = !w_held_q && !bvalid_q;
  assign arready = !rvalid_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign rvalid = rvalid_q;
  assign rresp = rresp_q;
  assign rdata = rdata_q;
  assign txd = txd_q;
  assign txd_oe = txd_oe_q;

  // Write address and data are taken in either order.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      waddr_q <= '0;
      wbyte_q <= 8'h00;
      wlane_q <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        aw_held_q <= 1'b1;
        waddr_q <= awaddr[11:2];
      end else if (do_write) begin
        aw_held_q <= 1'b0;
      end
      if (wvalid && wready) begin
        w_held_q <= 1'b1;
        wbyte_q <= wdata[7:0];
        wlane_q <= wstrb[0];
      end else if (do_write) begin
        w_held_q <= 1'b0;
      end
    end
  end

  // Write response; unmapped addresses answer with a slave error.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q <= (waddr_q >= IDX_CTRL_ONE && waddr_q <= IDX_DATA_LOW) ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Control registers and the transmit ninth bit; status registers ignore writes.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_one_q <= CTRL_RESET;
      ctrl_two_q <= CTRL_RESET;
      tx_ninth_q <= 1'b0;
    end else if (do_write && wlane_q) begin
      if (waddr_q == IDX_CTRL_ONE) begin
        ctrl_one_q <= wbyte_q;
      end
      if (waddr_q == IDX_CTRL_TWO) begin
        ctrl_two_q <= wbyte_q;
      end
      if (waddr_q == IDX_DATA_HIGH) begin
        tx_ninth_q <= wbyte_q[DH_TX_NINTH];
      end
    end
  end

  // Read data; data low returns the holding register, never the transmit queue.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h0000_0000;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h0000_0000;
      unique case (araddr[11:2])
        IDX_CTRL_ONE: rdata_q[7:0] <= ctrl_one_q;
        IDX_CTRL_TWO: rdata_q[7:0] <= ctrl_two_q;
        IDX_STATUS_ONE: rdata_q[7:0] <= flags_q;
        IDX_STATUS_TWO: rdata_q[0] <= (rx_state_q == RX_BITS);
        IDX_DATA_HIGH: rdata_q[7:6] <= {rx_hold_q[8], tx_ninth_q};
        IDX_DATA_LOW: rdata_q[7:0] <= rx_hold_q[7:0];
        default: rresp_q <= RESP_SLVERR;
      endcase
    end else if (rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // Sample tick, one in every SAMPLE_DIV cycles; sixteen ticks make one bit time.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q <= 4'h0;
    end else begin
      div_q <= (div_q == SAMPLE_DIV - 4'h1) ? 4'h0 : div_q + 4'h1;
    end
  end
  assign tick = (div_q == SAMPLE_DIV - 4'h1);

  // Transmit parity and frame, LSB first: start, data, parity or ninth bit, stop.
  logic par8, par9, tx_go, tx_end, bit_edge;
  logic [9:0] tx_body;
  assign par8 = ^tx_buf_q[6:0] ^ par_odd;
  assign par9 = ^tx_buf_q[7:0] ^ par_odd;
  always_comb begin
    if (nine) begin
      tx_body = {par_en ? par9 : tx_buf_q[8], tx_buf_q[7:0], 1'b0};
    end else begin
      tx_body = {1'b1, par_en ? par8 : tx_buf_q[7], tx_buf_q[6:0], 1'b0};
    end
  end
  assign bit_edge = tick && (tx_phase_q == LAST_PHASE);
  assign tx_go = bit_edge && (tx_state_q == TX_IDLE) && tx_pend_q && tx_on;
  assign tx_end = bit_edge && (tx_state_q == TX_SEND) && (tx_left_q == 4'h1);

  // Transmit shifter; once started a frame runs to its stop bit whatever the enable does.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_state_q <= TX_IDLE;
      tx_frame_q <= '1;
      tx_left_q <= 4'h0;
      tx_phase_q <= 4'h0;
      txd_q <= 1'b1;
    end else begin
      if (tick) begin
        tx_phase_q <= tx_phase_q + 4'h1;
      end
      if (tx_go) begin
        tx_state_q <= TX_SEND;
        tx_frame_q <= {1'b1, tx_body};
        tx_left_q <= nine ? FRAME_BITS_9 : FRAME_BITS_8;
        txd_q <= 1'b0;
      end else if (bit_edge && tx_state_q == TX_SEND) begin
        tx_frame_q <= {1'b1, tx_frame_q[10:1]};
        tx_left_q <= tx_left_q - 4'h1;
        txd_q <= tx_end ? 1'b1 : tx_frame_q[1];
        if (tx_end) begin
          tx_state_q <= TX_IDLE;
        end
      end
    end
  end

  // Transmit queue; clearing the enable throws away what is waiting.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_pend_q <= 1'b0;
      tx_buf_q <= '0;
    end else if (wr_low) begin
      tx_pend_q <= 1'b1;
      tx_buf_q <= {tx_ninth_q, wbyte_q};
    end else if (tx_go || !tx_on) begin
      tx_pend_q <= 1'b0;
    end
  end

  // Pin ownership changes only on bit boundaries, so release is bit-clock aligned.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      txd_oe_q <= 1'b0;
      tx_on_prev_q <= 1'b0;
    end else begin
      tx_on_prev_q <= tx_on;
      if (bit_edge) begin
        txd_oe_q <= tx_on || (tx_state_q == TX_SEND && !tx_end);
      end
    end
  end

  // Receive line synchroniser.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rxd_meta_q <= 2'b11;
    end else begin
      rxd_meta_q <= {rxd_meta_q[0], rxd};
    end
  end
  logic rxd_s;
  assign rxd_s = rxd_meta_q[1];

  // Receive vote and frame decode.
  logic maj, unanimous, rx_done, rx_load, rx_over, rx_fe, rx_pe;
  logic [3:0] rx_last;
  logic [8:0] rx_data;
  assign maj = (votes_q[0] & votes_q[1]) | (votes_q[1] & votes_q[2]) | (votes_q[0] & votes_q[2]);
  assign unanimous = (votes_q == 3'b000) || (votes_q == 3'b111);
  assign rx_last = (nine ? FRAME_BITS_9 : FRAME_BITS_8) - 4'h1;
  assign rx_done = tick && rx_state_q == RX_BITS && rx_phase_q == LAST_PHASE && rx_bit_q == rx_last;
  assign rx_data = nine ? rx_shift_q[9:1] : {1'b0, rx_shift_q[9:2]};
  assign rx_fe = !maj;
  assign rx_pe = par_en && ((^rx_data) != par_odd);
  assign rx_over = rx_done && (flags_q[FLAG_RX_FULL] || flags_q[FLAG_OVERRUN]);
  assign rx_load = rx_done && !rx_over;

  // Receive sequencer: start detect, three mid-bit votes, shift, stop check.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_state_q <= RX_IDLE;
      rx_phase_q <= 4'h0;
      rx_bit_q <= 4'h0;
      votes_q <= 3'b111;
      rx_shift_q <= '0;
      rx_noise_q <= 1'b0;
    end else if (!rx_on) begin
      rx_state_q <= RX_IDLE;
    end else if (tick) begin
      if (rx_state_q == RX_IDLE) begin
        if (!rxd_s) begin
          rx_state_q <= RX_BITS;
          rx_phase_q <= 4'h1;
          rx_bit_q <= 4'h0;
          rx_noise_q <= 1'b0;
        end
      end else begin
        rx_phase_q <= rx_phase_q + 4'h1;
        if (rx_phase_q == VOTE_A || rx_phase_q == VOTE_B || rx_phase_q == VOTE_C) begin
          votes_q <= {votes_q[1:0], rxd_s};
        end
        if (rx_phase_q == LAST_PHASE) begin
          rx_noise_q <= rx_noise_q || !unanimous;
          rx_bit_q <= rx_bit_q + 4'h1;
          if (rx_bit_q == 4'h0 && maj) begin
            rx_state_q <= RX_IDLE; // A false start is dropped.
          end else if (rx_bit_q == rx_last) begin
            rx_state_q <= RX_IDLE;
          end else if (rx_bit_q != 4'h0) begin
            rx_shift_q <= {maj, rx_shift_q[9:1]};
          end
        end
      end
    end
  end

  // Holding register; an overrun leaves the held character untouched.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_hold_q <= '0;
    end else if (rx_load) begin
      rx_hold_q <= rx_data;
    end
  end

  // Idle detector: a full character time of ones after activity.
  logic idle_hit;
  assign idle_hit = tick && rxd_s && ({4'h0, rx_last} + 8'h01) * 8'h10 == idle_cnt_q + 8'h01;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      idle_cnt_q <= 8'h00;
      line_active_q <= 1'b0;
    end else if (tick) begin
      idle_cnt_q <= (!rxd_s || idle_hit) ? 8'h00 : idle_cnt_q + 8'h01;
      if (!rxd_s && rx_on) begin
        line_active_q <= 1'b1;
      end else if (idle_hit) begin
        line_active_q <= 1'b0;
      end
    end
  end

  // Hardware set events for each status flag.
  always_comb begin
    flag_set = 8'h00;
    flag_set[FLAG_TX_EMPTY] = tx_go || (tx_on && !tx_on_prev_q) || (tx_end && !tx_on);
    flag_set[FLAG_TX_DONE] = (tx_end && !(tx_pend_q && tx_on)) || (tx_on && !tx_on_prev_q);
    flag_set[FLAG_RX_FULL] = rx_load;
    flag_set[FLAG_IDLE] = idle_hit && line_active_q && !mute;
    flag_set[FLAG_OVERRUN] = rx_over;
    flag_set[FLAG_NOISE] = rx_load && (rx_noise_q || !unanimous);
    flag_set[FLAG_FRAMING] = rx_load && rx_fe;
    flag_set[FLAG_PARITY] = rx_load && rx_pe;
  end

  // Transmit flags clear on a data write, receive flags on a data read.
  assign flag_clr = {wr_low, wr_low, {6{rd_low}}};

  // Per-flag arm and clear; a set in the clearing cycle wins.
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_flag
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          flags_q[gi] <= STATUS_ONE_RESET[gi];
          armed_q[gi] <= 1'b0;
        end else begin
          flags_q[gi] <= flag_set[gi] || (flags_q[gi] && !(armed_q[gi] && flag_clr[gi]));
          if (rd_status) begin
            armed_q[gi] <= flags_q[gi];
          end else if (flag_clr[gi]) begin
            armed_q[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // Single request line; noise, framing and parity flags never raise it, mute masks receiver sources.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= (ctrl_two_q[C2_TX_EMPTY_IRQ] && flags_q[FLAG_TX_EMPTY])
        || (ctrl_two_q[C2_TX_DONE_IRQ] && flags_q[FLAG_TX_DONE])
        || (!mute && ctrl_two_q[C2_RX_IRQ] && (flags_q[FLAG_RX_FULL] || flags_q[FLAG_OVERRUN]))
        || (!mute && ctrl_two_q[C2_IDLE_IRQ] && flags_q[FLAG_IDLE]);
    end
  end

endmodule

// ### verif/uart_status_data_flags_props.sv
// Port checker for the serial flag block.
`timescale 1ns/1ps
module uart_status_data_flags_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic rxd,
  input wire logic txd,
  input wire logic txd_oe,
  input wire logic irq
);
  logic [7:0] run_q; // Cycles the transmit pin has kept its level.
  logic last_q; // Pin level one cycle ago.
  // Starts saturated so the first bit after reset is not judged short.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_q <= 8'hFF;
      last_q <= 1'b1;
    end else begin
      last_q <= txd;
      run_q <= (txd != last_q) ? 8'h00 : ((run_q == 8'hFF) ? run_q : run_q + 8'h01);
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_bit_time_held: assert property ($changed(txd) |-> run_q >= 8'd31) else $error("bit too short");
  a_pin_owned_low: assert property (!txd |-> txd_oe) else $error("low while released");
  a_write_resp_due: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid) else $error("no bvalid");
  a_read_resp_due: assert property (arvalid && arready |=> rvalid) else $error("no rvalid");
  a_bresp_stands: assert property (bvalid && !bready |=> bvalid && $stable(bresp)) else $error("bresp moved");
  a_rdata_stands: assert property (rvalid && !rready |=> rvalid && $stable(rdata)) else $error("rdata moved");
  a_read_blocked: assert property (rvalid |-> !arready) else $error("arready with rvalid");
  a_write_blocked: assert property (bvalid |-> !awready && !wready) else $error("ready with bvalid");
  a_upper_zero: assert property (rvalid |-> rdata[31:8] == 24'h000000) else $error("upper bits set");
endmodule
bind uart_status_data_flags uart_status_data_flags_props u_props (
  .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(awprot), .awvalid(awvalid),
  .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
  .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(arprot),
  .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
  .rready(rready), .rxd(rxd), .txd(txd), .txd_oe(txd_oe), .irq(irq)
);

// ### verif/uart_peer.sv
// Remote serial node: sends frames on the receive pin and collects transmitted ones.
`timescale 1ns/1ps
module uart_peer (
  input wire logic aclk,
  input wire logic txd,
  input wire logic txd_oe,
  output logic rxd
);
  localparam int BIT_CLK = 32; // Clocks per bit at the fixed rate.
  logic [8:0] got_q[$]; // Characters seen on the transmit pin.
  initial rxd = 1'b1; // The line idles high.
  // One frame, LSB first; noisy flips one vote sample of the first data bit.
  task automatic send(input logic [8:0] d, input int n, input logic stop, input logic noisy);
    logic b;
    for (int i = 0; i <= n + 1; i++) begin
      b = (i == 0) ? 1'b0 : ((i <= n) ? d[i-1] : stop);
      for (int c = 0; c < BIT_CLK; c++) begin
        @(posedge aclk);
        rxd <= (noisy && i == 1 && (c == 15 || c == 16)) ? ~b : b;
      end
    end
    @(posedge aclk);
    rxd <= 1'b1;
  endtask
  // Samples eight data bits mid-bit; the pin only counts while the block owns it.
  initial begin
    logic [8:0] v;
    forever begin
      @(negedge txd);
      // The enable may rise at the same edge as the start bit, so it is read one edge later.
      @(posedge aclk);
      if (txd_oe) begin
        v = 9'h000;
        repeat (BIT_CLK / 2 - 1) @(posedge aclk);
        for (int i = 0; i < 8; i++) begin
          repeat (BIT_CLK) @(posedge aclk);
          v[i] = txd;
        end
        repeat (BIT_CLK) @(posedge aclk);
        got_q.push_back(v);
      end
    end
  end
endmodule

// ### verif/uart_status_data_flags_tb.sv
// Self-checking bench for the serial flag block.
`timescale 1ns/1ps
module uart_status_data_flags_tb;
  import uart_flags_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata;
  wire logic awready, wready, bvalid, arready, rvalid, rxd, txd, txd_oe, irq;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  int err_total = 0;
  int samples_checked = 0;
  uart_status_data_flags u_uart_status_data_flags (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .rxd(rxd), .txd(txd), .txd_oe(txd_oe), .irq(irq));
  uart_peer u_peer (.aclk(aclk), .txd(txd), .txd_oe(txd_oe), .rxd(rxd));
  // 25 MHz clock.
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  // Counts one comparison and reports a mismatch.
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Bus write; each channel is released at the edge it is taken.
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 200);
    chk(9'(bresp), 9'(RESP_OKAY));
    bready <= 1'b0;
  endtask
  // Bus read; data and response are taken at the edge rvalid is seen.
  task automatic rd(input logic [9:0] idx, output logic [7:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 200);
    d = rdata[7:0];
    r = rresp;
    rready <= 1'b0;
  endtask
  // Polls status one until a flag shows, with a bounded count.
  task automatic wait_flag(input int b);
    logic [7:0] s;
    logic [1:0] r;
    int n;
    n = 0;
    s = 8'h00;
    while (s[b] !== 1'b1 && n < 3000) begin
      rd(IDX_STATUS_ONE, s, r);
      n++;
    end
    chk(9'(s[b]), 9'h001);
  endtask
  // Status read then data read: the receive clear sequence.
  task automatic ack(output logic [7:0] d);
    logic [7:0] s;
    logic [1:0] r;
    rd(IDX_STATUS_ONE, s, r);
    rd(IDX_DATA_LOW, d, r);
  endtask
  // Reset values and an unmapped read.
  task automatic t_reset();
    logic [7:0] d;
    logic [1:0] r;
    rd(IDX_STATUS_ONE, d, r);
    chk(9'(d), 9'(STATUS_ONE_RESET));
    rd(IDX_STATUS_TWO, d, r);
    chk(9'(d), 9'h000);
    rd(10'h3FF, d, r);
    chk(9'(r), 9'(RESP_SLVERR));
    $display("test reset done");
  endtask
  // Receive, busy, interrupts, idle, overrun and mute.
  task automatic t_rx();
    logic [7:0] d, s;
    logic [1:0] r;
    wr(IDX_CTRL_TWO, 8'h24);
    fork
      u_peer.send(9'h03C, 8, 1'b1, 1'b0);
      begin
        repeat (100) @(posedge aclk);
        rd(IDX_STATUS_TWO, s, r);
        chk(9'(s), 9'h001);
      end
    join
    wait_flag(FLAG_RX_FULL);
    chk(9'(irq), 9'h001);
    ack(d);
    chk(9'(d), 9'h03C);
    rd(IDX_STATUS_ONE, s, r);
    chk(9'(s[FLAG_RX_FULL]), 9'h000);
    wait_flag(FLAG_IDLE);
    chk(9'(irq), 9'h000);
    wr(IDX_CTRL_TWO, 8'h34);
    @(posedge aclk); // The request line is registered one cycle behind the enable.
    chk(9'(irq), 9'h001);
    ack(d);
    repeat (800) @(posedge aclk);
    rd(IDX_STATUS_ONE, s, r);
    chk(9'(s[FLAG_IDLE]), 9'h000);
    wr(IDX_CTRL_TWO, 8'h24);
    u_peer.send(9'h011, 8, 1'b1, 1'b0);
    u_peer.send(9'h022, 8, 1'b1, 1'b0);
    wait_flag(FLAG_OVERRUN);
    ack(d);
    chk(9'(d), 9'h011);
    rd(IDX_STATUS_ONE, s, r);
    chk(9'(s[FLAG_OVERRUN]), 9'h000);
    wr(IDX_CTRL_TWO, 8'h26);
    u_peer.send(9'h044, 8, 1'b1, 1'b0);
    repeat (400) @(posedge aclk);
    chk(9'(irq), 9'h000);
    ack(d);
    wr(IDX_CTRL_TWO, 8'h04);
    $display("test receive done");
  endtask
  // Framing, noise and parity flags, each cleared by its sequence.
  task automatic t_err();
    logic [7:0] d, s;
    logic [1:0] r;
    u_peer.send(9'h055, 8, 1'b0, 1'b0);
    repeat (800) @(posedge aclk);
    wait_flag(FLAG_FRAMING);
    ack(d);
    rd(IDX_STATUS_ONE, s, r);
    chk(9'(s[FLAG_FRAMING]), 9'h000);
    u_peer.send(9'h00F, 8, 1'b1, 1'b1);
    wait_flag(FLAG_NOISE);
    ack(d);
    chk(9'(d), 9'h00F);
    wr(IDX_CTRL_ONE, 8'h02);
    u_peer.send(9'h001, 8, 1'b1, 1'b0);
    wait_flag(FLAG_PARITY);
    ack(d);
    u_peer.send(9'h081, 8, 1'b1, 1'b0);
    wait_flag(FLAG_RX_FULL);
    rd(IDX_STATUS_ONE, s, r);
    chk(9'(s[FLAG_PARITY]), 9'h000);
    ack(d);
    wr(IDX_CTRL_ONE, 8'h10);
    $display("test errors done");
  endtask
  // Nine-bit receive and the ninth-bit fields of data high.
  task automatic t_nine();
    logic [7:0] d;
    logic [1:0] r;
    wr(IDX_DATA_HIGH, 8'h40);
    u_peer.send(9'h1A5, 9, 1'b1, 1'b0);
    wait_flag(FLAG_RX_FULL);
    rd(IDX_DATA_HIGH, d, r);
    chk(9'(d), 9'h0C0);
    ack(d);
    chk(9'(d), 9'h0A5);
    wr(IDX_CTRL_ONE, 8'h00);
    $display("test nine-bit done");
  endtask
  // Transmit flags, interrupts and shutdown with a queued character.
  task automatic t_tx();
    logic [7:0] s;
    logic [1:0] r;
    wr(IDX_CTRL_TWO, 8'h08);
    rd(IDX_STATUS_ONE, s, r);
    chk(9'(s[7:6]), 9'h003);
    wr(IDX_DATA_LOW, 8'hA5);
    rd(IDX_STATUS_ONE, s, r);
    chk(9'(s[FLAG_TX_DONE]), 9'h000);
    wait_flag(FLAG_TX_EMPTY);
    wr(IDX_DATA_LOW, 8'h3C);
    rd(IDX_STATUS_ONE, s, r);
    chk(9'(s[FLAG_TX_EMPTY]), 9'h000);
    wr(IDX_CTRL_TWO, 8'h88);
    chk(9'(irq), 9'h000);
    wait_flag(FLAG_TX_EMPTY);
    chk(9'(irq), 9'h001);
    wr(IDX_DATA_LOW, 8'h77);
    wr(IDX_CTRL_TWO, 8'h00);
    wait_flag(FLAG_TX_DONE);
    rd(IDX_STATUS_ONE, s, r);
    chk(9'(s[7:6]), 9'h003);
    wr(IDX_CTRL_TWO, 8'h40);
    @(posedge aclk); // The request line is registered one cycle behind the enable.
    chk(9'(irq), 9'h001);
    repeat (64) @(posedge aclk);
    chk(9'(txd_oe), 9'h000);
    chk(9'(u_peer.got_q.size()), 9'h002);
    chk(u_peer.got_q[0], 9'h0A5);
    chk(u_peer.got_q[1], 9'h03C);
    $display("test transmit done");
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Cuts a hang well past the expected run length.
  initial begin
    repeat (80000) @(posedge aclk);
    err_total++;
    tally_and_finish();
  end
  // Main sequence.
  initial begin
    aresetn = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h00000000;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_rx();
    t_err();
    t_nine();
    t_tx();
    tally_and_finish();
  end
endmodule
